// File: src/fiws_seq.sv
/*
  Flash in-application programming sequencer: unlock, page erase, buffered page write
  and single-word read, with CPU stall while an operation runs.
  Assumes control strobes are one-cycle pulses synchronous to clk_i and that the flash
  array returns read data within the read time.
*/
// Behaviour
// - Erase mode plus trigger erases page, self-clears
// - Erase always covers one whole page
// - Write trigger copies buffer into flash, self-clears
// - Write trigger stays high about 2.2 ms
// - CPU halted while any operation runs
// - Whole buffer written inside one page
// - Buffer clear bit empties write buffer
// - Reprogram same page without erase allowed
// - Erase/write refused unless enabled flag set
// - Clearing enabled flag blocks erase and write
// - Read needs read mode, enable, trigger
// - Read word lands in data registers
// - Read trigger falls after three instruction cycles
// - Read works without the unlock
// - Buffer holds one 32-word page
// - High byte write advances pointer, saturating
// - Unlock mode, start bit, timed six-byte key
// - Correct key in window sets enabled flag
`timescale 1ns/10ps
`default_nettype none

module fiws_seq #(
  parameter int PROG_CYCLES   = fiws_pkg::PROG_CYCLES,
  parameter int UNLOCK_CYCLES = fiws_pkg::UNLOCK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Control bits from software
  input  wire logic [2:0]  op_mode_i,
  input  wire logic        read_enable_i,
  input  wire logic        write_trigger_set_i,
  input  wire logic        read_trigger_set_i,
  input  wire logic        buffer_clear_set_i,
  input  wire logic        unlock_start_set_i,
  input  wire logic        ew_enable_clear_i,
  // Register writes
  input  wire logic        addr_low_wr_i,
  input  wire logic        addr_high_wr_i,
  input  wire logic        data_low_wr_i,
  input  wire logic        data_high_wr_i,
  input  wire logic        key_wr_i,
  input  wire logic [2:0]  key_sel_i,
  input  wire logic [7:0]  wdata_i,
  // Status to software
  output logic             write_trigger_o,
  output logic             read_trigger_o,
  output logic             unlock_start_o,
  output logic             ew_enabled_o,
  output logic             cpu_stall_o,
  output logic [7:0]       data_low_o,
  output logic [7:0]       data_high_o,
  // Flash array
  output logic             flash_erase_o,
  output logic             flash_wr_o,
  output logic             flash_rd_o,
  output logic [12:0]      flash_addr_o,
  output logic [15:0]      flash_wdata_o,
  input  wire logic [15:0] flash_rdata_i
);

  localparam int IW = $clog2(fiws_pkg::PAGE_WORDS);
  localparam int CW = fiws_pkg::CNT_W;

  typedef struct packed {
    fiws_pkg::fiws_fsm_t                   st;
    logic                                  wt;
    logic                                  rt;
    logic                                  unl;
    logic                                  ewen;
    logic                                  stall;
    logic [fiws_pkg::ADDR_W-1:0]           addr;
    logic [7:0]                            dlo;
    logic [7:0]                            dhi;
    logic [CW-1:0]                         cnt;
    logic [CW-1:0]                         ucnt;
    logic [IW-1:0]                         idx;
    logic [fiws_pkg::KEY_BYTES-1:0]        keyok;
    logic                                  er;
    logic                                  wr;
    logic                                  rd;
    logic [fiws_pkg::ADDR_W-1:0]           faddr;
    logic [fiws_pkg::WORD_W-1:0]           fwdata;
  } fiws_seq_t;

  fiws_seq_t s_reg;
  fiws_seq_t s_next;

  logic [fiws_pkg::WORD_W-1:0] buf_data;
  logic                        buf_valid;
  logic                        key_done;
  logic                        idle;

  assign idle = (s_reg.st == fiws_pkg::ST_IDLE);

  fiws_wbuf #(
    .WORDS (fiws_pkg::PAGE_WORDS),
    .W     (fiws_pkg::WORD_W)
  ) u_wbuf (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .ptr_load_i (addr_low_wr_i),
    .ptr_val_i  (wdata_i[IW-1:0]),
    .wr_i       (data_high_wr_i),
    .wdata_i    ({wdata_i, s_reg.dlo}),
    .clear_i    (buffer_clear_set_i && idle),
    .rd_idx_i   (s_reg.idx),
    .rd_data_o  (buf_data),
    .rd_valid_o (buf_valid)
  );

  always_comb begin
    s_next    = s_reg;
    s_next.er = 1'b0;
    s_next.wr = 1'b0;
    s_next.rd = 1'b0;
    key_done  = 1'b0;

    if (addr_low_wr_i) begin
      s_next.addr[7:0] = wdata_i;
    end
    if (addr_high_wr_i) begin
      s_next.addr[fiws_pkg::ADDR_W-1:8] = wdata_i[fiws_pkg::ADDR_W-9:0];
    end
    if (data_low_wr_i) begin
      s_next.dlo = wdata_i;
    end
    if (data_high_wr_i) begin
      s_next.dhi = wdata_i;
    end

    // Unlock window: the start bit drops by itself when the timer runs out
    if (unlock_start_set_i && op_mode_i == fiws_pkg::MODE_UNLOCK) begin
      s_next.unl   = 1'b1;
      s_next.ucnt  = CW'(UNLOCK_CYCLES - 1);
      s_next.keyok = '0;
    end else if (s_reg.unl) begin
      if (s_reg.ucnt == '0) begin
        s_next.unl = 1'b0;
      end else begin
        s_next.ucnt = s_reg.ucnt - 1'b1;
      end
      if (key_wr_i && key_sel_i < 3'(fiws_pkg::KEY_BYTES)) begin
        s_next.keyok[key_sel_i] = (wdata_i == fiws_pkg::KEY_BYTE[key_sel_i]);
      end
      key_done = &s_next.keyok;
    end
    // Setting by a good key wins over a clear in the same cycle
    if (key_done) begin
      s_next.ewen  = 1'b1;
      s_next.keyok = '0;
    end else if (ew_enable_clear_i) begin
      s_next.ewen = 1'b0;
    end

    unique case (s_reg.st)
      fiws_pkg::ST_IDLE: begin
        if (write_trigger_set_i && s_reg.ewen) begin
          if (op_mode_i == fiws_pkg::MODE_ERASE) begin
            s_next.st    = fiws_pkg::ST_ERASE;
            s_next.wt    = 1'b1;
            s_next.stall = 1'b1;
            s_next.er    = 1'b1;
            s_next.faddr = {s_reg.addr[fiws_pkg::ADDR_W-1:fiws_pkg::PAGE_LSB], 5'h00};
            s_next.cnt   = CW'(PROG_CYCLES - 1);
          end else if (op_mode_i == fiws_pkg::MODE_WRITE) begin
            // No erase state is kept, so a page may be reprogrammed after a retry
            s_next.st    = fiws_pkg::ST_SCAN;
            s_next.wt    = 1'b1;
            s_next.stall = 1'b1;
            s_next.idx   = '0;
          end
        end else if (read_trigger_set_i && op_mode_i == fiws_pkg::MODE_READ && read_enable_i) begin
          s_next.st    = fiws_pkg::ST_READ;
          s_next.rt    = 1'b1;
          s_next.stall = 1'b1;
          s_next.rd    = 1'b1;
          s_next.faddr = s_reg.addr;
          s_next.cnt   = CW'(fiws_pkg::READ_CYCLES - 1);
        end
      end
      fiws_pkg::ST_SCAN: begin
        // Only loaded words reach the array; empty slots keep their flash content
        if (buf_valid) begin
          s_next.wr     = 1'b1;
          s_next.faddr  = {s_reg.addr[fiws_pkg::ADDR_W-1:fiws_pkg::PAGE_LSB], s_reg.idx};
          s_next.fwdata = buf_data;
        end
        if (s_reg.idx == IW'(fiws_pkg::PAGE_WORDS - 1)) begin
          s_next.st  = fiws_pkg::ST_WAIT;
          s_next.cnt = CW'(PROG_CYCLES - 1);
        end else begin
          s_next.idx = s_reg.idx + 1'b1;
        end
      end
      fiws_pkg::ST_ERASE,
      fiws_pkg::ST_WAIT: begin
        if (s_reg.cnt == '0) begin
          s_next.st    = fiws_pkg::ST_IDLE;
          s_next.wt    = 1'b0;
          s_next.stall = 1'b0;
        end else begin
          s_next.cnt = s_reg.cnt - 1'b1;
        end
      end
      fiws_pkg::ST_READ: begin
        if (s_reg.cnt == '0) begin
          s_next.st  = fiws_pkg::ST_IDLE;
          s_next.rt  = 1'b0;
          s_next.stall = 1'b0;
          s_next.dhi = flash_rdata_i[15:8];
          s_next.dlo = flash_rdata_i[7:0];
        end else begin
          s_next.cnt = s_reg.cnt - 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_reg     <= '0;
      s_reg.st  <= fiws_pkg::ST_IDLE;
      s_reg.dlo <= fiws_pkg::DATA_RST;
      s_reg.dhi <= fiws_pkg::DATA_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign write_trigger_o = s_reg.wt;
  assign read_trigger_o  = s_reg.rt;
  assign unlock_start_o  = s_reg.unl;
  assign ew_enabled_o    = s_reg.ewen;
  assign cpu_stall_o     = s_reg.stall;
  assign data_low_o      = s_reg.dlo;
  assign data_high_o     = s_reg.dhi;
  assign flash_erase_o   = s_reg.er;
  assign flash_wr_o      = s_reg.wr;
  assign flash_rd_o      = s_reg.rd;
  assign flash_addr_o    = s_reg.faddr;
  assign flash_wdata_o   = s_reg.fwdata;

  // Length of the running read trigger pulse; a counter keeps the read time check cheap to evaluate
  logic [4:0] rt_len_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rt_len_reg <= 5'h00;
    end else if (read_trigger_o) begin
      rt_len_reg <= rt_len_reg + 5'h01;
    end else begin
      rt_len_reg <= 5'h00;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  erase_refused_a : assert property (
    idle && write_trigger_set_i && !ew_enabled_o |=> !write_trigger_o && !flash_erase_o && !cpu_stall_o)
    else $error("erase or write started while locked");
  erase_start_a : assert property (
    idle && write_trigger_set_i && ew_enabled_o && op_mode_i == fiws_pkg::MODE_ERASE
      |=> flash_erase_o && write_trigger_o ##1 !flash_erase_o && write_trigger_o)
    else $error("erase not started as one pulse with trigger high");
  erase_page_a : assert property (
    flash_erase_o |-> flash_addr_o[4:0] == 5'h00 && flash_addr_o[12:5] == s_reg.addr[12:5])
    else $error("erase not aligned to the addressed page");
  stall_track_a : assert property (
    cpu_stall_o == (write_trigger_o || read_trigger_o))
    else $error("stall does not match a running operation");
  read_time_a : assert property (
    $fell(read_trigger_o) |-> rt_len_reg == 5'(fiws_pkg::READ_CYCLES))
    else $error("read trigger length wrong");
  read_hold_a : assert property (
    read_trigger_o |-> rt_len_reg < 5'(fiws_pkg::READ_CYCLES))
    else $error("read trigger held too long");
  read_data_a : assert property (
    $fell(read_trigger_o) |-> {data_high_o, data_low_o} == $past(flash_rdata_i))
    else $error("read data not captured");
  read_unlocked_a : assert property (
    idle && read_trigger_set_i && read_enable_i && op_mode_i == fiws_pkg::MODE_READ && !ew_enabled_o
      |=> read_trigger_o && flash_rd_o)
    else $error("read blocked without unlock");
  write_page_a : assert property (
    flash_wr_o |-> flash_addr_o[12:5] == s_reg.addr[12:5] && write_trigger_o)
    else $error("program word outside the page");
  ew_clear_a : assert property (
    ew_enable_clear_i && !unlock_start_o |=> !ew_enabled_o)
    else $error("enabled flag not cleared");
  key_window_a : assert property (
    $rose(ew_enabled_o) |-> $past(unlock_start_o) && $past(key_wr_i))
    else $error("enabled flag set outside key window");

  erase_done_c : cover property ($fell(write_trigger_o) && $past(s_reg.st) == fiws_pkg::ST_ERASE);
  prog_done_c  : cover property ($fell(write_trigger_o) && $past(s_reg.st) == fiws_pkg::ST_WAIT);
  read_done_c  : cover property ($fell(read_trigger_o));
  unlock_c     : cover property ($rose(ew_enabled_o));

endmodule

`default_nettype wire

// File: src/fiws_pkg.sv
/*
  Shared constants and types of the flash in-application programming sequencer.
  Assumes a 125 MHz system clock and a 13-bit word address into the program flash.
*/
`default_nettype none

package fiws_pkg;

  // Operation select codes
  localparam logic [2:0] MODE_WRITE  = 3'h0;
  localparam logic [2:0] MODE_ERASE  = 3'h1;
  localparam logic [2:0] MODE_READ   = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;

  // Geometry
  localparam int ADDR_W     = 13;
  localparam int WORD_W     = 16;
  localparam int PAGE_WORDS = 32;
  localparam int PAGE_LSB   = 5;
  localparam int KEY_BYTES  = 6;

  // Unlock key, in order low/high of the three auxiliary data words
  localparam logic [7:0] KEY_BYTE [KEY_BYTES] = '{8'h00, 8'h04, 8'h0d, 8'h09, 8'hc3, 8'h40};

  // Timing
  localparam int CLK_PERIOD_PS   = 8000;
  localparam int PROG_TIME_US    = 2200;
  // Worked in ns steps so the product stays inside a 32-bit int
  localparam int PROG_CYCLES     = (PROG_TIME_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int READ_INSTR      = 3;
  localparam int CLKS_PER_INSTR  = 4;
  localparam int READ_CYCLES     = READ_INSTR * CLKS_PER_INSTR;
  localparam int UNLOCK_CYCLES   = 1024;
  localparam int CNT_W           = 20;

  // Reset values
  localparam logic [7:0] DATA_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ERASE,
    ST_SCAN,
    ST_WAIT,
    ST_READ
  } fiws_fsm_t;

endpackage

`default_nettype wire

// File: src/fiws_wbuf.sv
/*
  Page write buffer: one page of words, a valid bit per word and a load pointer.
  Assumes the pointer is preset from the low address byte and loads are whole words.
*/
`timescale 1ns/10ps
`default_nettype none

module fiws_wbuf #(
  parameter int WORDS = fiws_pkg::PAGE_WORDS,
  parameter int W     = fiws_pkg::WORD_W
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     nrst_i,
  // Load side
  input  wire logic                     ptr_load_i,
  input  wire logic [$clog2(WORDS)-1:0] ptr_val_i,
  input  wire logic                     wr_i,
  input  wire logic [W-1:0]             wdata_i,
  input  wire logic                     clear_i,
  // Drain side
  input  wire logic [$clog2(WORDS)-1:0] rd_idx_i,
  output logic      [W-1:0]             rd_data_o,
  output logic                          rd_valid_o
);

  localparam int IW = $clog2(WORDS);

  typedef struct packed {
    logic [WORDS-1:0][W-1:0] mem;
    logic [WORDS-1:0]        vld;
    logic [IW-1:0]           ptr;
  } fiws_wbuf_t;

  fiws_wbuf_t s_reg;
  fiws_wbuf_t s_next;

  always_comb begin
    s_next = s_reg;
    if (ptr_load_i) begin
      s_next.ptr = ptr_val_i;
    end
    if (clear_i) begin
      s_next.vld = '0;
    end else if (wr_i) begin
      s_next.mem[s_reg.ptr] = wdata_i;
      s_next.vld[s_reg.ptr] = 1'b1;
      // Stop at the last word of the page instead of wrapping onto its start
      if (s_reg.ptr != IW'(WORDS - 1)) begin
        s_next.ptr = s_reg.ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data_o  = s_reg.mem[rd_idx_i];
  assign rd_valid_o = s_reg.vld[rd_idx_i];

endmodule

`default_nettype wire

// File: sim/fiws_flash_model.sv
/*
  Behavioural program flash array for the sequencer bench: 8K words, page erase,
  single-word program and registered word read.
  Assumes one-cycle erase, program and read pulses from the sequencer on clk_i.
*/
`timescale 1ns/10ps
`default_nettype none

module fiws_flash_model (
  // Clock
  input  wire logic        clk_i,
  // Array commands
  input  wire logic        erase_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [12:0] addr_i,
  input  wire logic [15:0] wdata_i,
  // Read data
  output logic      [15:0] rdata_o
);
  logic [15:0] mem [8192];

  // Nonzero start contents, so an erase or a stray write always shows
  initial begin
    rdata_o = 16'h0000;
    for (int i = 0; i < 8192; i++) mem[i] = 16'h9c00 ^ 16'(i);
  end

  always @(posedge clk_i) begin
    if (erase_i) begin
      for (int i = 0; i < 32; i++) mem[{addr_i[12:5], 5'(i)}] <= 16'h0000;
    end
    if (wr_i) mem[addr_i] <= wdata_i;
    if (rd_i) rdata_o <= mem[addr_i];
  end
endmodule

`default_nettype wire

// File: sim/test_flash_iap_write_read_sequencer.sv
/*
  Self-checking bench of the flash programming sequencer with a flash array model.
  Assumes inputs change at the falling edge and shortened program and unlock times.
*/
`timescale 1ns/10ps
`default_nettype none

module test_flash_iap_write_read_sequencer;
  localparam int          PROG = 20;
  localparam int          UNL  = 24;
  localparam logic [12:0] BASE = 13'h0260;

  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [2:0]  op_mode_i = 3'h0;
  logic        read_enable_i = 1'b0;
  logic [9:0]  stb = 10'h000;
  logic [2:0]  key_sel_i = 3'h0;
  logic [7:0]  wdata_i = 8'h00;
  logic        wt_o, rt_o, us_o, ew_o, stall_o, fe, fw, fr;
  logic [7:0]  dl_o, dh_o;
  logic [12:0] fa;
  logic [15:0] fwd, read_trigger_bit;
  logic        stall_bad = 1'b0;
  int          err_count = 0;
  int          total_checks = 0;
  int          cnt;

  fiws_seq #(.PROG_CYCLES(PROG), .UNLOCK_CYCLES(UNL)) u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .op_mode_i(op_mode_i), .read_enable_i(read_enable_i),
    .write_trigger_set_i(stb[4]), .read_trigger_set_i(stb[5]), .buffer_clear_set_i(stb[6]),
    .unlock_start_set_i(stb[7]), .ew_enable_clear_i(stb[8]), .addr_low_wr_i(stb[0]),
    .addr_high_wr_i(stb[1]), .data_low_wr_i(stb[2]), .data_high_wr_i(stb[3]),
    .key_wr_i(stb[9]), .key_sel_i(key_sel_i), .wdata_i(wdata_i), .write_trigger_o(wt_o),
    .read_trigger_o(rt_o), .unlock_start_o(us_o), .ew_enabled_o(ew_o), .cpu_stall_o(stall_o),
    .data_low_o(dl_o), .data_high_o(dh_o), .flash_erase_o(fe), .flash_wr_o(fw),
    .flash_rd_o(fr), .flash_addr_o(fa), .flash_wdata_o(fwd), .flash_rdata_i(read_trigger_bit));

  fiws_flash_model u_flash (
    .clk_i(clk_i), .erase_i(fe), .wr_i(fw), .rd_i(fr), .addr_i(fa), .wdata_i(fwd), .rdata_o(read_trigger_bit));

  always #4 clk_i = ~clk_i;

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One-cycle strobe; called and returns at a falling edge
  task automatic poke(input int k, input logic [7:0] d);
    wdata_i = d;
    stb[k] = 1'b1;
    @(negedge clk_i);
    stb[k] = 1'b0;
  endtask

  // Counts cycles while a status bit stays high: 0 write, 1 read, 2 unlock timer
  task automatic wait_low(input int sel, output int n);
    n = 0;
    stall_bad = 1'b0;
    while ((sel == 0 ? wt_o : sel == 1 ? rt_o : us_o) === 1'b1) begin
      if (sel < 2 && stall_o !== 1'b1) stall_bad = 1'b1;
      n++;
      @(negedge clk_i);
      if (n > 2000) begin
        err_count++;
        $display("Error wait_low expected low seen high");
        give_verdict();
      end
    end
  endtask

  // Idle cycle after each key so repeated key strobes stay separate
  task automatic keys(input int bad);
    for (int i = 0; i < 6; i++) begin
      key_sel_i = 3'(i);
      poke(9, i == bad ? 8'hc2 : fiws_pkg::KEY_BYTE[i]);
      @(negedge clk_i);
    end
  endtask

  task automatic word(input logic [15:0] w);
    poke(2, w[7:0]);
    poke(3, w[15:8]);
  endtask

  task automatic t_reset;
    chk("reset_status", {wt_o, rt_o, us_o, ew_o, stall_o, fe, fw, fr, dh_o, dl_o}, 24'h0);
  endtask

  task automatic t_refused;
    op_mode_i = fiws_pkg::MODE_ERASE;
    poke(4, 8'h00);
    chk("refused_trigger", {wt_o, stall_o, fe}, 24'h0);
  endtask

  task automatic t_unlock;
    op_mode_i = fiws_pkg::MODE_UNLOCK;
    poke(7, 8'h00);
    chk("unlock_start", us_o, 24'h1);
    keys(4);
    wait_low(2, cnt);
    chk("unlock_window", 24'(cnt), 24'(UNL - 12));
    chk("bad_key_flag", ew_o, 24'h0);
    keys(-1);
    chk("late_key_flag", ew_o, 24'h0);
    poke(7, 8'h00);
    keys(-1);
    chk("good_key_flag", ew_o, 24'h1);
    wait_low(2, cnt);
  endtask

  // Address inside the page on purpose: erase must still cover the whole page
  task automatic t_erase;
    op_mode_i = fiws_pkg::MODE_ERASE;
    poke(1, 8'h02);
    poke(0, 8'h65);
    poke(4, 8'h00);
    chk("erase_pulse", {fe, wt_o, stall_o, fa}, {3'h7, BASE});
    wait_low(0, cnt);
    chk("erase_time", 24'(cnt >= PROG && cnt <= PROG + 1), 24'h1);
    chk("erase_stall", {stall_bad, stall_o}, 24'h0);
    for (int i = 0; i < 32; i++) chk("erased_word", u_flash.mem[BASE + i], 24'h0);
    chk("page_below", u_flash.mem[BASE - 1], 24'(16'h9c00 ^ 16'(BASE - 1)));
    chk("page_above", u_flash.mem[BASE + 32], 24'(16'h9c00 ^ 16'(BASE + 32)));
  endtask

  // Three words from slot 30: the third lands on slot 31 as the pointer saturates
  task automatic t_write;
    op_mode_i = fiws_pkg::MODE_WRITE;
    poke(0, 8'h7e);
    word(16'hbeef);
    word(16'h1234);
    word(16'hcafe);
    poke(4, 8'h00);
    chk("write_busy", {wt_o, stall_o}, 24'h3);
    wait_low(0, cnt);
    chk("write_time", 24'(cnt >= PROG + 32 && cnt <= PROG + 33), 24'h1);
    chk("write_stall", {stall_bad, stall_o}, 24'h0);
    chk("slot30", u_flash.mem[BASE + 30], 24'hbeef);
    chk("slot31", u_flash.mem[BASE + 31], 24'hcafe);
    chk("slot29", u_flash.mem[BASE + 29], 24'h0);
  endtask

  // A corrupted word must survive the retry, proving the buffer was emptied
  task automatic t_retry;
    poke(6, 8'h00);
    u_flash.mem[BASE + 31] = 16'h5555;
    poke(0, 8'h65);
    word(16'h0a0b);
    poke(4, 8'h00);
    wait_low(0, cnt);
    chk("retry_word", u_flash.mem[BASE + 5], 24'h0a0b);
    chk("cleared_slot", u_flash.mem[BASE + 31], 24'h5555);
  endtask

  task automatic rd(input logic [7:0] lo, input logic [15:0] exp);
    poke(0, lo);
    poke(5, 8'h00);
    chk("read_busy", {rt_o, stall_o, fr}, 24'h7);
    wait_low(1, cnt);
    chk("read_time", 24'(cnt), 24'd12);
    chk("read_data", {dh_o, dl_o}, 24'(exp));
  endtask

  task automatic t_read;
    poke(8, 8'h00);
    chk("flag_cleared", ew_o, 24'h0);
    t_refused();
    op_mode_i = fiws_pkg::MODE_READ;
    poke(0, 8'h7f);
    poke(5, 8'h00);
    chk("read_no_enable", {rt_o, stall_o}, 24'h0);
    read_enable_i = 1'b1;
    rd(8'h7f, 16'h5555);
    rd(8'h7e, 16'hbeef);
  endtask

  initial begin
    repeat (3) @(negedge clk_i);
    nrst_i = 1'b1;
    @(negedge clk_i);
    t_reset();
    t_refused();
    t_unlock();
    t_erase();
    t_write();
    t_retry();
    t_read();
    give_verdict();
  end
endmodule

`default_nettype wire
